/* File: hw/adc_init_cfg.svh */
`ifndef ADC_INIT_CFG_SVH
`define ADC_INIT_CFG_SVH

// serial register address and data widths
`define REG_ADDR_W 12
`define REG_DATA_W 8

// soft reset control register and its bit
`define RESET_REG_ADDR 12'h000
`define SOFT_RESET_BIT 0

// number of default words held in fuses
`define FUSE_WORDS 16
`define FUSE_IDX_W 4

// calibration length in sampling-clock cycles
`define CAL_CYCLES 200000
`define CAL_CNT_W 18

`endif

/* File: hw/adc_init_pkg.sv */
`include "adc_init_cfg.svh"

package adc_init_pkg;

	// one default word pushed into the register file
	typedef struct packed {
		logic valid;
		logic [`REG_ADDR_W-1:0] addr;
		logic [`REG_DATA_W-1:0] data;
	} cfg_write_t;

	// register write as decoded by the serial front end
	typedef struct packed {
		logic strobe;
		logic [`REG_ADDR_W-1:0] addr;
		logic [`REG_DATA_W-1:0] data;
	} reg_write_t;

	typedef enum logic [3:0] {
		ST_RESET = 4'h1,
		ST_LOAD = 4'h2,
		ST_CAL = 4'h4,
		ST_READY = 4'h8
	} seq_state_t;

endpackage : adc_init_pkg

/* File: hw/adc_init_reset_sequencer.sv */
`timescale 1ns/1ps
`include "adc_init_cfg.svh"


module adc_init_reset_sequencer #(
	parameter int CAL_CYCLES = `CAL_CYCLES,
	parameter int FUSE_WORDS = `FUSE_WORDS
) (
	// sampling clock and power-on reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// pins
	input wire logic hw_reset_pin_i,
	input wire logic reference_buffer_select_pin_i,
	// decoded serial register writes
	input wire adc_init_pkg::reg_write_t reg_wr_i,
	// register file control
	output logic reg_clear_o,
	output adc_init_pkg::cfg_write_t cfg_wr_o,
	output logic soft_reset_bit_o,
	// status
	output logic calib_busy_o,
	output logic ready_o,
	output logic ref_buf_sel_o
);

	localparam int IDX_W = `FUSE_IDX_W;
	localparam int CNT_W = `CAL_CNT_W;
	localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(FUSE_WORDS - 1);
	localparam logic [CNT_W-1:0] CAL_LAST = CNT_W'(CAL_CYCLES - 1);

	// pin synchronisers; first stages read only by second stages
	logic [1:0] rst_sync_r;
	logic [1:0] rst_sync_nxt;
	logic [1:0] ref_sync_r;
	logic [1:0] ref_sync_nxt;
	logic pin_rst;

	always_comb begin
		rst_sync_nxt = {rst_sync_r[0], hw_reset_pin_i};
		ref_sync_nxt = {ref_sync_r[0], reference_buffer_select_pin_i};
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			rst_sync_r <= 2'h0;
			ref_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= rst_sync_nxt;
			ref_sync_r <= ref_sync_nxt;
		end
	end

	assign pin_rst = rst_sync_r[1];

	// soft reset request: bit D0 of the reset register written high
	function automatic logic is_soft_reset(input adc_init_pkg::reg_write_t w);
		return w.strobe && (w.addr == `RESET_REG_ADDR) && w.data[`SOFT_RESET_BIT];
	endfunction : is_soft_reset

	logic sw_req;
	assign sw_req = is_soft_reset(reg_wr_i);

	// sequencer state
	adc_init_pkg::seq_state_t state_r;
	adc_init_pkg::seq_state_t state_nxt;
	logic soft_bit_r;
	logic soft_bit_nxt;
	logic [IDX_W-1:0] fuse_idx_r;
	logic [IDX_W-1:0] fuse_idx_nxt;
	logic [IDX_W-1:0] pend_idx_r;
	logic [IDX_W-1:0] pend_idx_nxt;
	logic pend_r;
	logic pend_nxt;
	logic issuing_r;
	logic issuing_nxt;
	logic [CNT_W-1:0] cal_cnt_r;
	logic [CNT_W-1:0] cal_cnt_nxt;
	adc_init_pkg::cfg_write_t cfg_r;
	adc_init_pkg::cfg_write_t cfg_nxt;
	logic ref_r;
	logic ref_nxt;
	logic [`REG_DATA_W-1:0] fuse_q;

	fuse_rom u_fuse_rom (
		.sys_clk_i(sys_clk_i),
		.reset_i(reset_i),
		.addr_i(fuse_idx_r),
		.data_o(fuse_q)
	);

	always_comb begin
		state_nxt = state_r;
		soft_bit_nxt = soft_bit_r;
		fuse_idx_nxt = fuse_idx_r;
		pend_idx_nxt = fuse_idx_r;
		pend_nxt = 1'b0;
		issuing_nxt = issuing_r;
		cal_cnt_nxt = cal_cnt_r;
		ref_nxt = ref_r;
		cfg_nxt.valid = pend_r;
		cfg_nxt.addr = `REG_ADDR_W'(pend_idx_r);
		cfg_nxt.data = fuse_q;
		case (state_r)
			adc_init_pkg::ST_RESET: begin
				// registers held at default until the pin is released
				fuse_idx_nxt = '0;
				issuing_nxt = 1'b1;
				cal_cnt_nxt = '0;
				cfg_nxt.valid = 1'b0;
				if (!pin_rst) begin
					state_nxt = adc_init_pkg::ST_LOAD;
					soft_bit_nxt = 1'b0;
					// strap level caught at reset release
					ref_nxt = ref_sync_r[1];
				end
			end
			adc_init_pkg::ST_LOAD: begin
				if (issuing_r) begin
					pend_nxt = 1'b1;
					if (fuse_idx_r == LAST_IDX) begin
						issuing_nxt = 1'b0;
					end else begin
						fuse_idx_nxt = fuse_idx_r + 1'b1;
					end
				end
				// calibration follows the last fuse word by itself
				if (pend_r && pend_idx_r == LAST_IDX) begin
					state_nxt = adc_init_pkg::ST_CAL;
				end
			end
			adc_init_pkg::ST_CAL: begin
				if (cal_cnt_r == CAL_LAST) begin
					state_nxt = adc_init_pkg::ST_READY;
				end else begin
					cal_cnt_nxt = cal_cnt_r + 1'b1;
				end
			end
			adc_init_pkg::ST_READY: begin
			end
			default: begin
				state_nxt = adc_init_pkg::ST_RESET;
			end
		endcase
		// soft reset restarts the whole sequence from any state; set wins over clear
		if (sw_req) begin
			state_nxt = adc_init_pkg::ST_RESET;
			soft_bit_nxt = 1'b1;
		end
		// hardware pin forces ST_RESET while high; a soft reset write still sets the bit
		if (pin_rst) begin
			state_nxt = adc_init_pkg::ST_RESET;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			state_r <= adc_init_pkg::ST_RESET;
			soft_bit_r <= 1'b0;
			fuse_idx_r <= '0;
			pend_idx_r <= '0;
			pend_r <= 1'b0;
			issuing_r <= 1'b0;
			cal_cnt_r <= '0;
			cfg_r <= '0;
			ref_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			soft_bit_r <= soft_bit_nxt;
			fuse_idx_r <= fuse_idx_nxt;
			pend_idx_r <= pend_idx_nxt;
			pend_r <= pend_nxt;
			issuing_r <= issuing_nxt;
			cal_cnt_r <= cal_cnt_nxt;
			cfg_r <= cfg_nxt;
			ref_r <= ref_nxt;
		end
	end

	assign reg_clear_o = state_r[0];
	assign calib_busy_o = state_r[2];
	assign ready_o = state_r[3];
	assign cfg_wr_o = cfg_r;
	assign soft_reset_bit_o = soft_bit_r;
	assign ref_buf_sel_o = ref_r;

	// helper: calibration cycles completed so far; holds the full run length for one cycle after it ends, zero otherwise
	logic [CNT_W:0] cal_seen_r;
	logic [CNT_W:0] cal_seen_nxt;

	always_comb begin
		cal_seen_nxt = '0;
		if (state_r[2]) begin
			cal_seen_nxt = cal_seen_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			cal_seen_r <= '0;
		end else begin
			cal_seen_r <= cal_seen_nxt;
		end
	end

	soft_trigger_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		sw_req |=> (reg_clear_o && soft_bit_r))
		else $error("soft reset write did not enter reset");

	soft_self_clear_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(soft_bit_r && reg_clear_o && !pin_rst && !sw_req) |=> (!soft_bit_r && state_r == adc_init_pkg::ST_LOAD))
		else $error("soft reset bit not cleared by the device");

	load_after_release_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		// first word leaves the output register two cycles after load entry
		($fell(reg_clear_o) && !pin_rst && !sw_req) |-> (state_r == adc_init_pkg::ST_LOAD) ##2
			(cfg_r.valid && cfg_r.addr == '0))
		else $error("fuse load did not follow reset release");

	cal_after_load_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(calib_busy_o) |-> $past(state_r) == adc_init_pkg::ST_LOAD)
		else $error("calibration started without fuse load");

	cal_length_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		$rose(ready_o) |-> (cal_seen_r == (CNT_W+1)'(CAL_CYCLES)))
		else $error("calibration length wrong");

endmodule : adc_init_reset_sequencer

/* File: hw/fuse_rom.sv */
`timescale 1ns/1ps
`include "adc_init_cfg.svh"

module fuse_rom #(
	parameter int DATA_W = `REG_DATA_W,
	parameter int DEPTH = `FUSE_WORDS,
	parameter int ADDR_W = `FUSE_IDX_W,
	// arbitrary pattern standing in for trimmed fuse contents
	parameter logic [7:0] FUSE_SEED = 8'h5A
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// read port
	input wire logic [ADDR_W-1:0] addr_i,
	output logic [DATA_W-1:0] data_o
);

	logic [DATA_W-1:0] data_r;
	logic [DATA_W-1:0] data_nxt;

	function automatic logic [DATA_W-1:0] fuse_word(input logic [ADDR_W-1:0] a);
		logic [7:0] w;
		w = FUSE_SEED ^ {a[3:0], a[3:0]};
		return DATA_W'(w);
	endfunction : fuse_word

	always_comb begin
		data_nxt = fuse_word(addr_i);
	end

	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			data_r <= '0;
		end else begin
			data_r <= data_nxt;
		end
	end

	assign data_o = data_r;

endmodule : fuse_rom

/* File: verification/ctrl_model.sv */
`timescale 1ns/1ps
module ctrl_model (
	// clock
	input wire logic sys_clk_i,
	// pins and decoded writes
	output logic hw_pin_o,
	output logic ref_pin_o,
	output adc_init_pkg::reg_write_t reg_wr_o
);
	initial begin
		hw_pin_o = 1'b0;
		ref_pin_o = 1'b1;
		reg_wr_o = '0;
	end
	task automatic pin_reset(input int len);
		@(negedge sys_clk_i) hw_pin_o = 1'b1;
		repeat (len) @(negedge sys_clk_i);
		hw_pin_o = 1'b0;
	endtask : pin_reset
	// pin stays low here; released fields show inverted junk
	task automatic write_reg(input logic [11:0] a, input logic [7:0] d);
		@(negedge sys_clk_i) reg_wr_o = '{1'b1, a, d};
		@(negedge sys_clk_i) reg_wr_o = '{1'b0, ~a, ~d};
	endtask : write_reg
endmodule : ctrl_model

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
	localparam int CAL = 20;
	localparam int WORDS = 16;
	logic sys_clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic hw_pin, ref_pin, reg_clear, soft_bit, busy, ready, ref_sel;
	adc_init_pkg::reg_write_t reg_wr;
	adc_init_pkg::cfg_write_t cfg_wr;
	int err_count = 0;
	int check_count = 0;
	int cycles = 0;
	int busy_len = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	ctrl_model u_ctrl (.sys_clk_i(sys_clk_i), .hw_pin_o(hw_pin), .ref_pin_o(ref_pin), .reg_wr_o(reg_wr));
	adc_init_reset_sequencer #(.CAL_CYCLES(CAL), .FUSE_WORDS(WORDS)) DUT (.sys_clk_i(sys_clk_i),
		.reset_i(reset_i), .hw_reset_pin_i(hw_pin), .reference_buffer_select_pin_i(ref_pin),
		.reg_wr_i(reg_wr), .reg_clear_o(reg_clear), .cfg_wr_o(cfg_wr), .soft_reset_bit_o(soft_bit),
		.calib_busy_o(busy), .ready_o(ready), .ref_buf_sel_o(ref_sel));
	// length of the current busy run, ends at the edge that raises ready
	always @(posedge sys_clk_i) begin
		busy_len <= (busy === 1'b1) ? busy_len + 1 : 0;
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// defaults stream out in order, then calibration runs its full length
	task automatic expect_load_cal;
		int n;
		n = 0;
		while (cfg_wr.valid !== 1'b1 && n < 10) begin
			@(negedge sys_clk_i);
			n++;
		end
		for (int i = 0; i < WORDS; i++) begin
			check({cfg_wr.valid, cfg_wr.addr}, {1'b1, 12'(i)});
			check(cfg_wr.data, 8'h5A ^ {2{4'(i)}});
			@(negedge sys_clk_i);
		end
		check(cfg_wr.valid, 0);
		n = 0;
		while (ready !== 1'b1 && n < CAL + 10) begin
			check(ready, 0);
			@(negedge sys_clk_i);
			n++;
		end
		check(busy_len, CAL);
		check({busy, ready}, 2'b01);
	endtask : expect_load_cal
	task automatic power_up;
		u_ctrl.pin_reset(4);
		check({reg_clear, ready}, 2'b10);
		expect_load_cal();
		check(ref_sel, 1);
	endtask : power_up
	// writes that must not reset, then the real one; bit clears alone
	task automatic soft_reset;
		u_ctrl.write_reg(12'h001, 8'h01);
		u_ctrl.write_reg(12'h000, 8'hFE);
		check({soft_bit, reg_clear, ready}, 3'b001);
		u_ctrl.write_reg(12'h000, 8'h01);
		check({soft_bit, reg_clear}, 2'b11);
		@(negedge sys_clk_i);
		check(soft_bit, 0);
		expect_load_cal();
	endtask : soft_reset
	// restarts in mid-calibration and mid-load
	task automatic restarts;
		u_ctrl.write_reg(12'h000, 8'h01);
		repeat (WORDS + 8) @(negedge sys_clk_i);
		check(busy, 1);
		u_ctrl.write_reg(12'h000, 8'h03);
		check({reg_clear, busy, ready}, 3'b100);
		repeat (6) @(negedge sys_clk_i);
		u_ctrl.pin_reset(2);
		// pin needs two sync stages; let the word in flight drain first
		repeat (2) @(negedge sys_clk_i);
		check(reg_clear, 1);
		expect_load_cal();
	endtask : restarts
	initial begin
		repeat (3) @(posedge sys_clk_i);
		@(negedge sys_clk_i) reset_i = 1'b0;
		power_up();
		soft_reset();
		restarts();
		complete_run();
	end
endmodule : tb
